// File: rate_spi_pkg.sv
// Shared constants for the rate sensor serial port and its master
// ==========================================================================
package rate_spi_pkg;
  // Frame layout
  localparam int          FRAME_BITS     = 16;
  localparam int          WR_FLAG_BIT    = 15;
  localparam int          ADDR_MSB       = 14;
  localparam int          ADDR_LSB       = 8;
  // Register byte addresses (lower byte of each word)
  localparam logic [6:0]  ADDR_TEMP      = 7'h02;
  localparam logic [6:0]  ADDR_RATE_EXT  = 7'h04;
  localparam logic [6:0]  ADDR_RATE_PRI  = 7'h06;
  localparam logic [6:0]  ADDR_DEC_SET   = 7'h22;
  localparam logic [6:0]  ADDR_GLOBAL_COMMAND  = 7'h28;
  localparam int          SAVE_BIT       = 3;
  localparam logic [15:0] DEC_RESET      = 16'h0000;
  localparam logic [15:0] ZERO_VALUE     = 16'h0000;
  // Timing
  localparam int          CLK_MHZ        = 125;
  localparam int          SCLK_KHZ_MAX   = 2500;
  localparam int          SCLK_DIV       = (CLK_MHZ * 1000 + 2 * SCLK_KHZ_MAX - 1) / (2 * SCLK_KHZ_MAX);
  localparam int          STALL_US       = 15;
  localparam int          STALL_CYC      = STALL_US * CLK_MHZ;
  localparam int          SAMPLE_CYC     = 61035;
  localparam int          DR_PULSE_CYC   = 4;
endpackage

// File: rate_spi_if.sv
// Serial link between rate sensor and its master
`timescale 1ns/1ps
`default_nettype none
interface rate_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  // Resolve the shared data-out line; floats high when nobody drives
  assign miso = miso_oe ? miso_o : 1'b1;
  modport dev  (input sclk, cs_n, mosi, output miso_o, miso_oe);
  modport host (output sclk, cs_n, mosi, input miso);
endinterface
`default_nettype wire

// File: rate_spi_device.sv
// Rate sensor serial slave with output registers and config store
`timescale 1ns/1ps
`default_nettype none
module rate_spi_device #(
  parameter int SAMPLE_CYCLES = rate_spi_pkg::SAMPLE_CYC
) (
  // Clock and reset
  input  wire logic      i_core_clk,
  input  wire logic      i_sys_rst,
  // Serial link
  rate_spi_if.dev        spi,
  // Sensor data from the signal chain
  input  wire logic [15:0] i_rate_pri,
  input  wire logic [15:0] i_rate_ext,
  input  wire logic [15:0] i_temp,
  // Status
  output logic           o_sample_done_pin,
  output logic [15:0]    o_decimation_setting,
  output logic           o_flash_busy
);
  import rate_spi_pkg::*;

  // ========================================================================
  // Pin synchronisers
  logic [1:0] sclk_s_q, cs_s_q, mosi_s_q;
  logic       sclk_d1_q;
  always_ff @(posedge i_core_clk) begin
    sclk_s_q  <= {sclk_s_q[0], spi.sclk};
    cs_s_q    <= {cs_s_q[0], spi.cs_n};
    mosi_s_q  <= {mosi_s_q[0], spi.mosi};
    sclk_d1_q <= sclk_s_q[1];
  end
  wire sclk_rise = sclk_s_q[1] & ~sclk_d1_q;
  wire sclk_fall = ~sclk_s_q[1] & sclk_d1_q;
  wire cs_act    = ~cs_s_q[1];

  // ========================================================================
  // Sampling engine: free running from reset
  logic [31:0] smp_cnt_q;
  logic [2:0]  dr_cnt_q;
  logic [15:0] temp_q, ext_q, pri_q;
  logic [15:0] ext_mask;
  // Decimation working copy, read by the mask below, and its mirror
  logic [15:0] dec_q, dec_nv_q;
  wire         smp_tick = (smp_cnt_q == 32'(SAMPLE_CYCLES - 1));
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      smp_cnt_q <= '0;
      temp_q    <= ZERO_VALUE;
      ext_q     <= ZERO_VALUE;
      pri_q     <= ZERO_VALUE;
    end else begin
      smp_cnt_q <= smp_tick ? '0 : smp_cnt_q + 32'd1;
      if (smp_tick) begin
        pri_q  <= i_rate_pri;
        ext_q  <= i_rate_ext & ext_mask;
        temp_q <= i_temp;
      end
    end
  end
  // MSB-justified mask of dec_q[4:0]-many bits, at most 16
  always_comb begin
    ext_mask = '0;
    for (int i = 0; i < 16; i++) begin
      if (i < int'(dec_q[4:0])) ext_mask[15-i] = 1'b1;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) dr_cnt_q <= '0;
    else if (smp_tick) dr_cnt_q <= 3'(DR_PULSE_CYC);
    else if (dr_cnt_q != 3'd0) dr_cnt_q <= dr_cnt_q - 3'd1;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) o_sample_done_pin <= 1'b0;
    else o_sample_done_pin <= smp_tick | (dr_cnt_q > 3'd1);
  end

  // ========================================================================
  // Working and nonvolatile copy of the decimation setting
  logic        busy_q;
  // Frame decode
  logic [15:0] sh_q;
  logic [4:0]  bit_q;
  logic        frame_done;
  wire  [15:0] frame_w = {sh_q[14:0], mosi_s_q[1]};
  wire         is_wr   = frame_w[WR_FLAG_BIT];
  wire  [6:0]  f_addr  = frame_w[ADDR_MSB:ADDR_LSB];
  wire  [7:0]  f_data  = frame_w[7:0];
  assign frame_done = cs_act & sclk_rise & (bit_q == 5'(FRAME_BITS - 1));
  wire   save_req   = frame_done & is_wr & (f_addr == ADDR_GLOBAL_COMMAND) & f_data[SAVE_BIT];
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      dec_q  <= dec_nv_q;
      busy_q <= 1'b0;
    end else begin
      busy_q <= save_req;
      if (frame_done & is_wr & (f_addr == ADDR_DEC_SET)) dec_q[7:0] <= f_data;
      if (frame_done & is_wr & (f_addr == (ADDR_DEC_SET | 7'h01))) dec_q[15:8] <= f_data;
    end
  end
  // Mirror has no reset: it models storage surviving reset
  logic nv_init_q = 1'b0;
  always_ff @(posedge i_core_clk) begin
    if (!nv_init_q) dec_nv_q <= DEC_RESET;
    else if (save_req) dec_nv_q <= dec_q;
    nv_init_q <= 1'b1;
  end
  assign o_decimation_setting = dec_q;
  assign o_flash_busy         = busy_q;

  // ========================================================================
  // Shift engine
  logic [15:0] tx_q;
  logic        rd_pend_q, drive_q, out_q;
  // Read mux, word chosen by even address
  logic [15:0] rd_word;
  always_comb begin
    unique case ({f_addr[6:1], 1'b0})
      ADDR_TEMP:     rd_word = temp_q;
      ADDR_RATE_EXT: rd_word = ext_q;
      ADDR_RATE_PRI: rd_word = pri_q;
      ADDR_DEC_SET:  rd_word = dec_q;
      default:       rd_word = 16'h0000;
    endcase
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || !cs_act) begin
      bit_q   <= '0;
      drive_q <= 1'b0;
      if (i_sys_rst) begin
        rd_pend_q <= 1'b0;
        tx_q      <= '0;
      end
    end else begin
      if (sclk_rise) begin
        sh_q  <= frame_w;
        bit_q <= frame_done ? 5'd0 : bit_q + 5'd1;
        if (frame_done) begin
          rd_pend_q <= ~is_wr;
          tx_q      <= rd_word;
        end
      end
      // launch on falling edge; only after read
      if (sclk_fall) begin
        drive_q <= rd_pend_q;
        out_q   <= tx_q[15];
        tx_q    <= {tx_q[14:0], 1'b0};
      end
    end
  end
  assign spi.miso_o  = out_q;
  assign spi.miso_oe = drive_q & cs_act;
endmodule
`default_nettype wire

// File: rate_spi_host.sv
// SPI master end that talks to the rate sensor
`timescale 1ns/1ps
`default_nettype none
module rate_spi_host (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  // Serial link
  rate_spi_if.host         spi,
  // User request
  input  wire logic        i_req,
  input  wire logic [15:0] i_frame,
  output logic             o_ready,
  output logic             o_done,
  output logic [15:0]      o_rx
);
  import rate_spi_pkg::*;
  typedef enum logic [1:0] {IDLE, SHIFT, STALL} st_t;
  st_t         st_q;
  logic [15:0] tx_q, rx_q;
  logic [4:0]  cnt_q;
  logic [15:0] div_q, gap_q;
  logic        sclk_q, cs_q, mosi_q, done_q;
  logic        ready_q;
  logic [1:0]  miso_s_q;
  // divider keeps clock at or below limit
  wire tick = (div_q == 16'(SCLK_DIV - 1));
  always_ff @(posedge i_core_clk) begin
    miso_s_q <= {miso_s_q[0], spi.miso};
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_q <= IDLE; sclk_q <= 1'b1; cs_q <= 1'b1; mosi_q <= 1'b1;
      div_q <= '0; gap_q <= '0; cnt_q <= '0; done_q <= 1'b0;
      tx_q <= '0; rx_q <= '0;
      ready_q <= 1'b1;
    end else begin
      done_q <= 1'b0;
      div_q  <= tick ? 16'd0 : div_q + 16'd1;
      unique case (st_q)
        IDLE: if (i_req) begin
          tx_q <= i_frame; cs_q <= 1'b0; cnt_q <= '0; div_q <= '0; st_q <= SHIFT;
          // Ready is a flop that tracks the idle state exactly
          ready_q <= 1'b0;
        end
        SHIFT: if (tick) begin
          // mode 3: change on fall, capture on rise
          if (sclk_q) begin
            sclk_q <= 1'b0; mosi_q <= tx_q[15]; tx_q <= {tx_q[14:0], 1'b0};
          end else begin
            sclk_q <= 1'b1; rx_q <= {rx_q[14:0], miso_s_q[1]};
            cnt_q  <= cnt_q + 5'd1;
            if (cnt_q == 5'(FRAME_BITS - 1)) begin
              st_q <= STALL; gap_q <= '0;
            end
          end
        end
        STALL: begin
          cs_q  <= 1'b1;
          gap_q <= gap_q + 16'd1;
          if (gap_q == 16'h0000) done_q <= 1'b1;
          if (gap_q == 16'(STALL_CYC - 1)) begin
            st_q    <= IDLE;
            ready_q <= 1'b1;
          end
        end
        // Unused state code falls back to idle
        default: begin
          st_q    <= IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end
  assign spi.sclk = sclk_q;
  assign spi.cs_n = cs_q;
  assign spi.mosi = mosi_q;
  assign o_ready  = ready_q;
  assign o_done   = done_q;
  assign o_rx     = rx_q;
endmodule
`default_nettype wire

// File: rate_spi_monitor.sv
// Checker for the serial link between the two rate sensor ends
`timescale 1ns/1ps
`default_nettype none
module rate_spi_monitor
  import rate_spi_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Link wires
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  // ==========
  // Frame tracking
  logic        sclk_q, cs_q, wr_q, rd_q;
  logic [15:0] gap_q, hi_q;
  logic [4:0]  rise_q;
  wire         rise = sclk & ~sclk_q;
  wire         ends = cs_n & ~cs_q;
  // Idle counters saturate so long gaps never wrap
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sclk_q <= 1'b1;
      cs_q   <= 1'b1;
      gap_q  <= 16'hffff;
      hi_q   <= 16'hffff;
      rise_q <= 5'h00;
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
    end else begin
      sclk_q <= sclk;
      cs_q   <= cs_n;
      gap_q  <= (sclk != sclk_q) ? 16'h0000 : gap_q + {15'h0000, ~&gap_q};
      hi_q   <= cs_n ? hi_q + {15'h0000, ~&hi_q} : 16'h0000;
      rise_q <= cs_n ? 5'h00 : rise_q + {4'h0, rise};
      wr_q   <= (rise && rise_q == 5'h00) ? mosi : wr_q;
      rd_q   <= ends ? ~wr_q : rd_q;
    end
  end
  // ==========
  // Link properties
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  a_idle_clock_high: assert property (cs_n |-> sclk) else $error("clock not high at idle");
  a_clock_rate_limit: assert property (sclk != sclk_q |-> gap_q >= 16'd24) else $error("clock too fast");
  a_mosi_hold_rise: assert property (!cs_n && $rose(sclk) |-> $stable(mosi) ##1 $stable(mosi))
    else $error("data in moved at rise");
  a_miso_change_low: assert property (!cs_n && miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sclk)
    else $error("data out moved while clock high");
  a_sixteen_rises: assert property (ends |-> rise_q == 5'd16) else $error("frame not 16 bits");
  a_oe_after_read: assert property (!cs_n && miso_oe |-> rd_q) else $error("driven after write");
  a_read_drives_out: assert property (!cs_n && rd_q && $fell(sclk) |-> ##[0:6] miso_oe)
    else $error("answer not driven");
  a_release_when_idle: assert property (cs_n [*4] |-> !miso_oe && miso) else $error("out not released");
  a_stall_gap_kept: assert property ($fell(cs_n) |-> hi_q >= STALL_CYC) else $error("stall too short");
  // Main scenarios reached
  c_read_frame: cover property (ends && !wr_q);
  c_write_frame: cover property (ends && wr_q);
  c_answer_out: cover property (miso_oe && !cs_n);
endmodule
`default_nettype wire

// File: spi_rate_sensor_register_port_tb.sv
// Self-checking bench joining the sensor end to its master end
`timescale 1ns/1ps
`default_nettype none
module spi_rate_sensor_register_port_tb;
  import rate_spi_pkg::*;
  // ==========
  // Stimulus and observation
  logic        clk = 1'b0, rst = 1'b1, req = 1'b0, sd_q = 1'b0;
  logic        done, ready, sdone, fbusy;
  logic [15:0] frame = 16'h0000, pri, ext, tmp, rx, dec;
  logic [7:0]  rb;
  integer      seed = 73, errors = 0, n_checks = 0, saves = 0, pulses = 0;
  logic [15:0] expq[$];
  always #4 clk = ~clk;
  rate_spi_if link ();
  rate_spi_device #(.SAMPLE_CYCLES(200)) rate_spi_device_i (.i_core_clk(clk), .i_sys_rst(rst), .spi(link),
    .i_rate_pri(pri), .i_rate_ext(ext), .i_temp(tmp), .o_sample_done_pin(sdone),
    .o_decimation_setting(dec), .o_flash_busy(fbusy));
  rate_spi_host rate_spi_host_i (.i_core_clk(clk), .i_sys_rst(rst), .spi(link), .i_req(req),
    .i_frame(frame), .o_ready(ready), .o_done(done), .o_rx(rx));
  rate_spi_monitor rate_spi_monitor_i (.i_core_clk(clk), .i_sys_rst(rst), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe), .miso(link.miso));
  // ==========
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One frame; returns once the master is idle again after its stall
  task automatic xfer(input logic [15:0] f, input logic [15:0] want);
    int n;
    expq.push_back(want);
    req = 1'b1;
    frame = f;
    @(negedge clk);
    req = 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n == 5000) begin
      errors++;
      give_verdict();
    end
  endtask
  // Each finished frame retires the oldest note; pulses counted by rising edge
  always @(negedge clk) begin
    if (done === 1'b1 && expq.size() == 0) errors++;
    else if (done === 1'b1) check(rx, expq.pop_front());
    if (fbusy === 1'b1) saves++;
    if (sdone === 1'b1 && sd_q !== 1'b1) pulses++;
    sd_q = sdone;
  end
  // ==========
  // Main sequence
  initial begin
    pri = 16'($random(seed));
    ext = 16'($random(seed));
    tmp = 16'($random(seed));
    rb = 8'($random(seed));
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    xfer(16'ha203, 16'hffff);
    xfer({8'ha3, rb}, 16'hffff);
    check(dec, {rb, 8'h03});
    xfer(16'ha808, 16'hffff);
    check(16'(saves), 16'h0001);
    xfer(16'ha255, 16'hffff);
    check(dec, {rb, 8'h55});
    $display("test config done");
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(dec, {rb, 8'h03});
    pulses = 0;
    repeat (2000) @(negedge clk);
    check(16'(pulses), 16'd10);
    xfer(16'h0600, 16'hffff);
    xfer(16'h0400, pri);
    xfer(16'h0200, {ext[15:13], 13'h0000});
    xfer(16'h3000, tmp);
    xfer(16'h0700, 16'h0000);
    xfer(16'h8600, pri);
    xfer(16'h0600, 16'hffff);
    xfer(16'h0000, pri);
    repeat (10) @(negedge clk);
    $display("test reads done");
    give_verdict();
  end
  // Roughly 35k cycles expected; allow about twice that
  initial begin
    #600000;
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
